// File: rtl/tlviu_top.sv
// Purpose: vectored interrupt unit with two priority levels for the core
// Assumes: core marks each finished instruction with instr_done
// Notes:   enable and priority bit meanings follow source order
`timescale 1ns/100ps
`include "tlviu_regs.svh"

// What this block does
// (R1) sample and arbitrate requests every clock
// (R2) shortest response: detect, instruction, five-clock call
// (R3) one instruction after return before next call
// (R4) worst response nineteen clocks via return and divide
// (R5) equal or higher active routine blocks requests
// (R6) reset vector zero, always highest, never masked
// (R7) vectors 0x0003 step eight, fixed order 0..18
// (R8) hardware clears sources 0..3 flags on vectoring
// (R9) supply warning vector 0x007B from read-only status
// (R10) software masks read-only sources to stop re-entry
// (R11) clock alarm and oscillator flags held indirectly
// (R12) one enable, one priority bit per source
// (R13) port match request follows comparator directly
// (R14) global enable gates requests, flags stay pending
// (R15) flags set regardless of enable, re-request after return
// (R16) high preempts low, never preempted, low default
module tlviu_top
    import tlviu_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic [`TLVIU_NUM_SRC-1:0] src_set,
    input  wire logic                      ext_input0_pin,
    input  wire logic                      ext_input1_pin,
    input  wire logic                      main_supply_good,
    input  wire logic                      battery_supply_good,
    input  wire logic                      port_match_hit,
    input  tlviu_cfg_wr_type               cfg_wr,
    input  wire logic                      flag_wr_en,
    input  wire logic [`TLVIU_NUM_SRC-1:0] flag_wr_data,
    input  wire logic                      ind_wr_en,
    input  wire logic [1:0]                ind_wr_data,
    input  wire logic                      instr_done,
    input  wire logic                      instr_is_return_from_irq,
    output tlviu_call_type                 call,
    output logic                           call_busy,
    output tlviu_cfg_type                  cfg,
    output logic [`TLVIU_NUM_SRC-1:0]      pending_flags,
    output logic [1:0]                     rtc_flags,
    output logic [1:0]                     in_service
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin and supply status synchronisers

    logic [1:0] pin_meta_ff;    // first stage, read only by pin_sync_ff
    logic [1:0] pin_sync_ff;    // safe pin levels
    logic [1:0] pin_last_ff;    // previous level for edge detection
    logic [1:0] sup_meta_ff;    // supply status first stage
    logic [1:0] sup_sync_ff;    // supply status, {battery, main}

    // pins and the analog monitor sit outside the clock domain
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta_ff <= 2'h0;
            pin_sync_ff <= 2'h0;
            pin_last_ff <= 2'h0;
            sup_meta_ff <= 2'h3;
            sup_sync_ff <= 2'h3;
        end else begin
            pin_meta_ff <= {ext_input1_pin, ext_input0_pin};
            pin_sync_ff <= pin_meta_ff;
            pin_last_ff <= pin_sync_ff;
            sup_meta_ff <= {battery_supply_good, main_supply_good};
            sup_sync_ff <= sup_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers, all clear at reset so every source is low

    tlviu_cfg_type cfg_ff;   // enable and priority registers
    tlviu_cfg_type nxt_cfg;  // after this cycle's write

    // one register per write, selected by one-hot code
    always_comb begin
        nxt_cfg = cfg_ff;
        if (cfg_wr.en) begin
            case (cfg_wr.sel)
                TLVIU_SEL_PRIM_EN: nxt_cfg.primary_enable_reg   = cfg_wr.data;
                TLVIU_SEL_PRIM_PR: nxt_cfg.primary_priority_reg = cfg_wr.data;
                TLVIU_SEL_EXTA_EN: nxt_cfg.ext_enable_reg_a     = cfg_wr.data;
                TLVIU_SEL_EXTA_PR: nxt_cfg.ext_priority_reg_a   = cfg_wr.data;
                TLVIU_SEL_EXTB_EN: nxt_cfg.ext_enable_reg_b     = cfg_wr.data;
                TLVIU_SEL_EXTB_PR: nxt_cfg.ext_priority_reg_b   = cfg_wr.data;
                default:           nxt_cfg = cfg_ff;
            endcase
        end
    end

    // low priority everywhere after reset: see (R16)
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) cfg_ff <= '0;
        else     cfg_ff <= nxt_cfg;
    end
    assign cfg = cfg_ff;

    // bit per source: 0..6 primary, 7..14 ext a, 15..18 ext b: see (R12)
    wire [`TLVIU_NUM_SRC-1:0] src_en = {cfg_ff.ext_enable_reg_b[3:0],
        cfg_ff.ext_enable_reg_a, cfg_ff.primary_enable_reg[`TLVIU_PRIM_SRC-1:0]};
    wire [`TLVIU_NUM_SRC-1:0] src_pr = {cfg_ff.ext_priority_reg_b[3:0],
        cfg_ff.ext_priority_reg_a, cfg_ff.primary_priority_reg[`TLVIU_PRIM_SRC-1:0]};
    wire                      global_irq_enable = cfg_ff.primary_enable_reg[`TLVIU_GLOBAL_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // pending flags

    logic [`TLVIU_NUM_SRC-1:0] flags_ff;  // direct flags, no-flag bits stay zero
    logic [1:0]                rtc_ff;    // {osc fail, alarm} in indirect space
    logic                      call_fire; // vectoring in this cycle
    tlviu_win_type             win_ff;    // winner sampled last cycle

    // pins raise the external flags on a rising edge
    wire [1:0]                pin_rise = pin_sync_ff & ~pin_last_ff;
    wire [`TLVIU_NUM_SRC-1:0] set_evt  = (src_set | {16'h0000, pin_rise[1], 1'b0, pin_rise[0]})
                                         & ~`TLVIU_NOFLAG_MASK;
    // vectoring clears only the external and first two timer flags: see (R8)
    wire [`TLVIU_NUM_SRC-1:0] hw_clr   = call_fire ?
        (`TLVIU_HWCLR_MASK & (19'h00001 << win_ff.idx)) : '0;
    wire [`TLVIU_NUM_SRC-1:0] sw_val   = flag_wr_en ? flag_wr_data : flags_ff;
    // a set arriving with a clear wins, whatever the enable: see (R15)
    wire [`TLVIU_NUM_SRC-1:0] nxt_flags = ((sw_val & ~hw_clr) | set_evt) & ~`TLVIU_NOFLAG_MASK;
    wire [1:0]                rtc_set   = {src_set[`TLVIU_IDX_OSCF], src_set[`TLVIU_IDX_ALARM]};
    wire [1:0]                nxt_rtc   = (ind_wr_en ? ind_wr_data : rtc_ff) | rtc_set;

    // flags are plain storage, updated every clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_ff <= '0;
            rtc_ff   <= 2'h0;
        end else begin
            flags_ff <= nxt_flags;
            rtc_ff   <= nxt_rtc;   // indirect space keeps these: see (R11)
        end
    end
    assign pending_flags = flags_ff;
    assign rtc_flags     = rtc_ff;

    // warning follows the read-only supply status: see (R9)
    wire warn_req = ~sup_sync_ff[0] | ~sup_sync_ff[1];
    // read-only sources re-request until masked by software: see (R10)
    wire [`TLVIU_NUM_SRC-1:0] pend_all = flags_ff
        | ({19{rtc_ff[0]}} & (19'h00001 << `TLVIU_IDX_ALARM))
        | ({19{rtc_ff[1]}} & (19'h00001 << `TLVIU_IDX_OSCF))
        | ({19{warn_req}} & (19'h00001 << `TLVIU_IDX_WARN))
        | ({19{port_match_hit}} & (19'h00001 << `TLVIU_IDX_MATCH)); // see (R13)
    // global gate leaves flags untouched: see (R14)
    wire [`TLVIU_NUM_SRC-1:0] elig = pend_all & src_en & {19{global_irq_enable}};

    ////////////////////////////////////////////////////////////////////////////////
    // arbitration, sampled every clock: see (R1)

    tlviu_win_type win_now;  // combinational winner

    tlviu_arbiter u_arb (
        .req  (elig),
        .prio (src_pr),
        .win  (win_now)
    );

    // the sample costs the one detection clock: see (R2)
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) win_ff <= '0;
        else     win_ff <= win_now;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    tlviu_state_type state_ff, nxt_state;
    logic [2:0]      cnt_ff;      // clocks left of the long call
    logic            block_ff;    // one instruction owed after a return
    logic            act_hi_ff;   // high routine running
    logic            act_lo_ff;   // low routine running
    tlviu_call_type  call_ff;     // call order, one-cycle pulse

    wire in_run   = (state_ff == TLVIU_ST_RUN);
    wire return_from_irq_end = in_run & instr_done & instr_is_return_from_irq;
    // high never preempted, low only by high: see (R16)
    wire level_ok = ~act_hi_ff & (~act_lo_ff | win_ff.hi);
    // equal or higher active routine holds off the request: see (R5)
    // after a return one instruction runs first, so a return plus a
    // divide bounds the response at nineteen clocks: see (R3) see (R4)
    assign call_fire = in_run & instr_done & ~instr_is_return_from_irq
                       & win_ff.valid & level_ok;

    // next state of the sequencer
    always_comb begin
        case (state_ff)
            TLVIU_ST_RUN:  nxt_state = call_fire ? TLVIU_ST_CALL : TLVIU_ST_RUN;
            TLVIU_ST_CALL: nxt_state = (cnt_ff == 3'h1) ? TLVIU_ST_RUN : TLVIU_ST_CALL;
            default:       nxt_state = TLVIU_ST_RUN;
        endcase
    end

    // vector address from fixed order: see (R7)
    wire [15:0] vec_addr = `TLVIU_VEC_BASE + {8'h00, win_ff.idx, 3'h0};

    // reset loads vector zero and nothing can mask it: see (R6)
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= TLVIU_ST_RUN;
            cnt_ff   <= 3'h0;
            call_ff  <= '{valid: 1'b0, hi: 1'b1, idx: 5'h00, addr: `TLVIU_RESET_VEC};
        end else begin
            state_ff      <= nxt_state;
            call_ff.valid <= call_fire;
            if (call_fire) begin
                call_ff.hi   <= win_ff.hi;
                call_ff.idx  <= win_ff.idx;
                call_ff.addr <= vec_addr;
            end
            // long call holds the core five clocks: see (R2)
            if (call_fire)        cnt_ff <= `TLVIU_CALL_CYC;
            else if (cnt_ff != 0) cnt_ff <= cnt_ff - 3'h1;
        end
    end

    // nesting record; a return retires the highest running level
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            block_ff  <= 1'b0;
            act_hi_ff <= 1'b0;
            act_lo_ff <= 1'b0;
        end else begin
            if (return_from_irq_end)                      block_ff <= 1'b1;
            else if (in_run & instr_done)      block_ff <= 1'b0;
            if (call_fire & win_ff.hi)         act_hi_ff <= 1'b1;
            else if (return_from_irq_end)                 act_hi_ff <= 1'b0;
            if (call_fire & ~win_ff.hi)        act_lo_ff <= 1'b1;
            else if (return_from_irq_end & ~act_hi_ff)    act_lo_ff <= 1'b0;
        end
    end

    assign call       = call_ff;
    assign call_busy  = (state_ff == TLVIU_ST_CALL);
    assign in_service = {act_hi_ff, act_lo_ff};

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_call_length: assert property ($rose(call_busy) |-> // see (R2)
        call_busy [*5] ##1 !call_busy)
        else $error("long call did not last five clocks");
    a_vector_map: assert property (call.valid |-> // see (R7)
        call.addr == 16'h0003 + 16'(call.idx) * 16'h0008 && call.idx <= 5'h12)
        else $error("vector address does not match source");
    a_one_after_return_from_irq: assert property (block_ff && instr_done && !instr_is_return_from_irq // see (R3)
        && win_ff.valid && level_ok |-> call_fire)
        else $error("no call after the instruction that follows a return");
    a_hw_clear: assert property (call_fire && win_ff.idx < 5'h04 // see (R8)
        && !set_evt[win_ff.idx] |=> !flags_ff[$past(win_ff.idx)])
        else $error("vectored flag not cleared");
    a_sw_flag_keep: assert property (call_fire && win_ff.idx > 5'h03 // see (R8)
        && win_ff.idx < 5'h08 && flags_ff[win_ff.idx] && !flag_wr_en
        |=> flags_ff[$past(win_ff.idx)])
        else $error("software flag cleared by hardware");
    a_global_gate: assert property (call.valid |-> $past(global_irq_enable, 2)) // see (R14)
        else $error("call while globally disabled");
    a_hi_no_preempt: assert property (act_hi_ff |-> !call_fire) // see (R16)
        else $error("high routine preempted");
    a_lo_only_hi: assert property (act_lo_ff && call_fire |-> win_ff.hi) // see (R5)
        else $error("low routine preempted by low request");
    a_warn_vector: assert property (call.valid && call.idx == 5'h0f |-> // see (R9)
        call.addr == 16'h007b)
        else $error("warning vector wrong");
    a_match_direct: assert property (port_match_hit && src_en[16] && global_irq_enable // see (R13)
        && !(|(elig & 19'h0ffff)) && !(|(elig & src_pr & 19'h60000))
        |=> win_ff.valid && win_ff.idx == 5'h10)
        else $error("port match not requested");

    c_preempt: cover property (act_lo_ff && call_fire);
    c_return_from_irq_then_call: cover property (return_from_irq_end ##[1:9] call_fire);
    c_last_source: cover property (call.valid && call.addr == 16'h0093);

endmodule : tlviu_top

// File: rtl/tlviu_regs.svh
// Purpose: constants of the two-level vectored interrupt unit
// Assumes: one 40 MHz system clock, nineteen maskable sources
// Notes:   definitions only, no logic
`ifndef TLVIU_REGS_SVH
`define TLVIU_REGS_SVH

`define TLVIU_NUM_SRC     19              // maskable sources, fixed order 0..18
`define TLVIU_RESET_VEC   16'h0000        // reset vector, above every source
`define TLVIU_VEC_BASE    16'h0003        // vector of source 0
`define TLVIU_VEC_LAST    16'h0093        // vector of source 18
`define TLVIU_VEC_STEP    16'h0008        // bytes between two vectors
`define TLVIU_CALL_CYC    3'h5            // clocks of the long call
`define TLVIU_DETECT_CYC  1               // clocks to detect a request
`define TLVIU_MIN_RESP    7               // shortest response in clocks
`define TLVIU_DIV_CYC     8               // longest instruction in clocks
`define TLVIU_MAX_RESP    19              // longest response in clocks
`define TLVIU_PRIM_SRC    7               // sources held in the primary registers
`define TLVIU_GLOBAL_BIT  7               // global enable bit of primary enable
`define TLVIU_HWCLR_MASK  19'h0000f       // sources 0..3 cleared on vectoring
`define TLVIU_IDX_EXT0    5'h00           // first external input
`define TLVIU_IDX_EXT1    5'h02           // second external input
`define TLVIU_IDX_ALARM   5'h08           // clock alarm, indirect flag
`define TLVIU_IDX_WARN    5'h0f           // supply early warning
`define TLVIU_IDX_MATCH   5'h10           // port match, no stored flag
`define TLVIU_IDX_OSCF    5'h11           // oscillator fail, indirect flag
`define TLVIU_IDX_LAST    5'h12           // last source
`define TLVIU_NOFLAG_MASK 19'h38100       // sources whose flag is not a direct one

`endif

// File: rtl/tlviu_pkg.sv
// Purpose: types of the two-level vectored interrupt unit
// Assumes: constants come from tlviu_regs.svh
// Notes:   carriers between the unit and the core
package tlviu_pkg;

    // which configuration register a write lands in
    typedef enum logic [5:0] {
        TLVIU_SEL_PRIM_EN = 6'h01,
        TLVIU_SEL_PRIM_PR = 6'h02,
        TLVIU_SEL_EXTA_EN = 6'h04,
        TLVIU_SEL_EXTA_PR = 6'h08,
        TLVIU_SEL_EXTB_EN = 6'h10,
        TLVIU_SEL_EXTB_PR = 6'h20
    } tlviu_sel_type;

    // sequencer states
    typedef enum logic [1:0] {
        TLVIU_ST_RUN  = 2'h1,
        TLVIU_ST_CALL = 2'h2
    } tlviu_state_type;

    // configuration write from the core
    typedef struct packed {
        logic          en;
        tlviu_sel_type sel;
        logic [7:0]    data;
    } tlviu_cfg_wr_type;

    // configuration registers as seen by software
    typedef struct packed {
        logic [7:0] primary_enable_reg;
        logic [7:0] primary_priority_reg;
        logic [7:0] ext_enable_reg_a;
        logic [7:0] ext_priority_reg_a;
        logic [7:0] ext_enable_reg_b;
        logic [7:0] ext_priority_reg_b;
    } tlviu_cfg_type;

    // arbitration winner
    typedef struct packed {
        logic       valid;
        logic       hi;
        logic [4:0] idx;
    } tlviu_win_type;

    // long call order to the core
    typedef struct packed {
        logic        valid;
        logic        hi;
        logic [4:0]  idx;
        logic [15:0] addr;
    } tlviu_call_type;

endpackage : tlviu_pkg

// File: rtl/tlviu_arbiter.sv
// Purpose: picks one request by priority level, then by fixed order
// Assumes: requests already gated by enables
// Notes:   purely combinational, resolved anew every clock
`timescale 1ns/100ps
`include "tlviu_regs.svh"

module tlviu_arbiter
    import tlviu_pkg::*;
(
    input  wire logic [`TLVIU_NUM_SRC-1:0] req,
    input  wire logic [`TLVIU_NUM_SRC-1:0] prio,
    output tlviu_win_type                  win
);

    logic [`TLVIU_NUM_SRC-1:0] req_hi;   // requests at high level
    logic [`TLVIU_NUM_SRC-1:0] pick;     // the level that competes
    logic [`TLVIU_NUM_SRC-1:0] first;    // lowest set bit of pick
    logic [`TLVIU_NUM_SRC-1:0] lower;    // some lower index already set

    assign req_hi = req & prio;
    // high level wins over any order
    assign pick   = (|req_hi) ? req_hi : req;

    // a lower order number wins within one level
    assign lower[0] = 1'b0;
    assign first[0] = pick[0];
    genvar g;
    generate
        for (g = 1; g < `TLVIU_NUM_SRC; g = g + 1) begin : g_chain
            assign lower[g] = lower[g-1] | pick[g-1];
            assign first[g] = pick[g] & ~lower[g];
        end
    endgenerate

    // encode the one-hot winner
    always_comb begin
        win.valid = |pick;
        win.hi    = |req_hi;
        win.idx   = 5'h00;
        for (int i = 0; i < `TLVIU_NUM_SRC; i++) begin
            if (first[i]) begin
                win.idx = 5'(i);
            end
        end
    end

endmodule : tlviu_arbiter

// File: dv/tlviu_core_model.sv
// Purpose: core side model that retires instructions and takes long calls
// Assumes: the bench gives length and return mark of each instruction
// Notes:   no instruction runs while the call sequence is busy
`timescale 1ns/100ps

module tlviu_core_model
    import tlviu_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       call_busy,
    input  wire logic [3:0] next_len,
    input  wire logic       next_return_from_irq,
    output logic            instr_done,
    output logic            instr_is_return_from_irq
);
    logic [3:0] left_ff; // clocks left in the current instruction
    logic       return_from_irq_ff; // current instruction is a return

    ////////////////////////////////////////////////////////////////////////////
    // load the next instruction at the end of the last one, and keep loading
    // while busy so the first one after the call starts as busy drops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            left_ff <= 4'h1;
            return_from_irq_ff <= 1'b0;
        end else if (call_busy || left_ff == 4'h1) begin
            left_ff <= next_len;
            return_from_irq_ff <= next_return_from_irq;
        end else begin
            left_ff <= left_ff - 4'h1;
        end
    end

    // held low in reset so no instruction seems to end before release
    assign instr_done    = !rst && !call_busy && left_ff == 4'h1;
    assign instr_is_return_from_irq = instr_done && return_from_irq_ff;
endmodule : tlviu_core_model

// File: dv/test_tlviu_top.sv
// Purpose: self-checking bench of the vectored interrupt unit
// Assumes: one-clock instructions unless a scenario asks otherwise
// Notes:   expected vectors and timings are worked out here
`timescale 1ns/100ps
`include "tlviu_regs.svh"

module test_tlviu_top
    import tlviu_pkg::*;
;
    logic                      core_clk, rst;
    logic [`TLVIU_NUM_SRC-1:0] src_set, flag_wr_data, pending_flags;
    logic                      pin0, pin1, vgood, bgood, match_hit;
    tlviu_cfg_wr_type          cfg_wr;
    logic                      flag_wr_en, ind_wr_en, instr_done, instr_is_return_from_irq;
    logic [1:0]                ind_wr_data, rtc_flags, in_service;
    tlviu_call_type            call;
    logic                      call_busy;
    tlviu_cfg_type             cfg, exp_cfg;   // exp_cfg: mirror of written values
    logic [3:0]                next_len;       // length of next instruction
    logic                      next_return_from_irq;      // next instruction is a return
    int                        cyc, t0, t_ret; // cycle count, request and return times
    int                        err_total, total_checks;

    tlviu_top DUT (.core_clk(core_clk), .rst(rst), .src_set(src_set),
        .ext_input0_pin(pin0), .ext_input1_pin(pin1), .main_supply_good(vgood),
        .battery_supply_good(bgood), .port_match_hit(match_hit), .cfg_wr(cfg_wr),
        .flag_wr_en(flag_wr_en), .flag_wr_data(flag_wr_data), .ind_wr_en(ind_wr_en),
        .ind_wr_data(ind_wr_data), .instr_done(instr_done),
        .instr_is_return_from_irq(instr_is_return_from_irq), .call(call), .call_busy(call_busy), .cfg(cfg),
        .pending_flags(pending_flags), .rtc_flags(rtc_flags), .in_service(in_service));

    tlviu_core_model core (.core_clk(core_clk), .rst(rst), .call_busy(call_busy),
        .next_len(next_len), .next_return_from_irq(next_return_from_irq), .instr_done(instr_done),
        .instr_is_return_from_irq(instr_is_return_from_irq));

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock and a cycle count for latency checks
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // one register write, then the whole register image is compared
    task automatic cfg_write(input tlviu_sel_type sel, input logic [7:0] d);
        @(posedge core_clk);
        cfg_wr <= '{en: 1'b1, sel: sel, data: d};
        @(posedge core_clk);
        cfg_wr.en <= 1'b0;
        case (sel)
            TLVIU_SEL_PRIM_EN: exp_cfg.primary_enable_reg = d;
            TLVIU_SEL_PRIM_PR: exp_cfg.primary_priority_reg = d;
            TLVIU_SEL_EXTA_EN: exp_cfg.ext_enable_reg_a = d;
            TLVIU_SEL_EXTB_EN: exp_cfg.ext_enable_reg_b = d;
            TLVIU_SEL_EXTA_PR: exp_cfg.ext_priority_reg_a = d;
            TLVIU_SEL_EXTB_PR: exp_cfg.ext_priority_reg_b = d;
            default: ; // unknown selects leave the image alone
        endcase
        @(negedge core_clk);
        check(cfg, exp_cfg);
    endtask : cfg_write

    // raise source i by the path that feeds it
    task automatic raise(input int i);
        @(posedge core_clk);
        case (i)
            0: pin0 <= 1'b1;
            2: pin1 <= 1'b1;
            15: vgood <= 1'b0;
            16: match_hit <= 1'b1;
            default: src_set[i] <= 1'b1;
        endcase
        @(negedge core_clk);
        t0 = cyc;
        @(posedge core_clk);
        src_set <= '0;
    endtask : raise

    // software side clears; flags in keep stay pending
    task automatic clear_src(input int i, input logic [`TLVIU_NUM_SRC-1:0] keep);
        @(posedge core_clk);
        {pin0, pin1, match_hit} <= 3'h0;
        {flag_wr_en, ind_wr_en} <= 2'h3;
        flag_wr_data <= keep;
        ind_wr_data <= 2'h0;
        @(posedge core_clk);
        {flag_wr_en, ind_wr_en} <= 2'h0;
        if (i == 15)
            cfg_write(TLVIU_SEL_EXTB_EN, 8'h0e);
    endtask : clear_src

    // a five-clock return, followed by an instruction of len_after clocks
    task automatic retire(input logic [3:0] len_after);
        int n;
        n = 0;
        @(posedge core_clk);
        next_len <= 4'h5;
        next_return_from_irq <= 1'b1;
        @(posedge core_clk);
        next_return_from_irq <= 1'b0;
        next_len <= len_after;
        do begin
            @(negedge core_clk);
            n++;
        end while (!(instr_done === 1'b1 && instr_is_return_from_irq === 1'b1) && n < 20);
        check(instr_is_return_from_irq, 1'b1);
        t_ret = cyc;
        @(posedge core_clk);
        next_len <= 4'h1;
    endtask : retire

    // wait for a call; t_exp of zero skips the timing compare
    task automatic wait_call(input logic [15:0] addr, input int t_exp, input logic hi);
        int n;
        int busy;
        n = 0;
        busy = 0;
        @(negedge core_clk);
        while (call.valid !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        check(call.valid, 1'b1);
        if (t_exp > 0)
            check(48'(cyc), 48'(t_exp));
        check(call.addr, addr);
        check(call.hi, hi);
        repeat (8) begin
            if (call_busy === 1'b1)
                busy++;
            @(negedge core_clk);
        end
        check(48'(busy), 48'd5);
    endtask : wait_call

    task automatic expect_quiet(input int n);
        int cnt;
        cnt = 0;
        repeat (n) begin
            @(negedge core_clk);
            if (call.valid !== 1'b0)
                cnt++;
        end
        check(48'(cnt), 48'd0);
    endtask : expect_quiet

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst, vgood, bgood} = 3'h7;
        {pin0, pin1, match_hit, flag_wr_en, ind_wr_en, next_return_from_irq} = 6'h0;
        {src_set, flag_wr_data, ind_wr_data} = '0;
        cfg_wr = '0;
        exp_cfg = '0;
        next_len = 4'h1;
        {cyc, err_total, total_checks} = '0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check(call.addr, 16'h0000);
        check(call.valid, 1'b0);
        check(cfg, exp_cfg);
        cfg_write(TLVIU_SEL_PRIM_EN, 8'hff);
        cfg_write(TLVIU_SEL_EXTA_EN, 8'hff);
        cfg_write(TLVIU_SEL_EXTB_EN, 8'h0f);
        cfg_write(tlviu_sel_type'(6'h03), 8'h55);
        for (int i = 0; i < `TLVIU_NUM_SRC; i++) begin
            raise(i);
            wait_call(16'h0003 + 16'(i) * 16'h0008,
                      (i inside {0, 2, 15, 16}) ? 0 : t0 + 3, 1'b0);
            if (i != 15 && i != 16)
                check((i == 8) ? rtc_flags[0] : (i == 17) ? rtc_flags[1] :
                      pending_flags[i], i > 3);
            clear_src(i, '0);
            retire(4'h1);
            expect_quiet(10);
        end
        @(posedge core_clk);
        vgood <= 1'b1;
        cfg_write(TLVIU_SEL_EXTB_EN, 8'h0f);
        // global enable off: the flag waits, then is taken
        cfg_write(TLVIU_SEL_PRIM_EN, 8'h7f);
        raise(4);
        expect_quiet(10);
        check(pending_flags[4], 1'b1);
        cfg_write(TLVIU_SEL_PRIM_EN, 8'hff);
        wait_call(16'h0023, 0, 1'b0);
        // equal level waits, high level preempts and is never preempted
        raise(5);
        expect_quiet(10);
        cfg_write(TLVIU_SEL_PRIM_PR, 8'h40);
        raise(6);
        wait_call(16'h0033, t0 + 3, 1'b1);
        check(in_service, 2'h3);
        expect_quiet(10);
        clear_src(6, 19'h00030);
        retire(4'h1);
        expect_quiet(10);
        // return then an eight-clock divide: call right after the divide
        retire(4'h8);
        wait_call(16'h0023, t_ret + 9, 1'b0);
        clear_src(4, '0);
        retire(4'h1);
        expect_quiet(10);
        // a low battery status alone raises the warning vector
        @(posedge core_clk);
        bgood <= 1'b0;
        wait_call(16'h007b, 0, 1'b0);
        @(posedge core_clk);
        bgood <= 1'b1;
        retire(4'h1);
        expect_quiet(10);
        // extended priority registers take what is written
        cfg_write(TLVIU_SEL_EXTA_PR, 8'h81);
        cfg_write(TLVIU_SEL_EXTB_PR, 8'h09);
        finish_test();
    end

    // watchdog: the whole run takes about 800 clocks
    initial begin
        repeat (6000) @(posedge core_clk);
        err_total++;
        finish_test();
    end
endmodule : test_tlviu_top
